/* File: rtl/ppt_defines.svh */
`ifndef PPT_DEFINES_SVH
`define PPT_DEFINES_SVH

// function codes (octal 0000..0025 shown in hex)
`define PPT_FC_REL_DISC   12'h000
`define PPT_FC_DISASM     12'h001
`define PPT_FC_CHAR       12'h002
`define PPT_FC_CLEAR      12'h005
`define PPT_FC_SEL_BASE   12'h010
`define PPT_FC_REL_BASE   12'h011

// connect code: unit number field position
`define PPT_CONN_N_LSB    9

// status word bit positions
`define PPT_ST_READY      0
`define PPT_ST_BUSY       1
`define PPT_ST_STOP       2
`define PPT_ST_IRQ_LSB    7

// wishbone register byte offsets and reset values
`define PPT_ADR_CTRL      8'h00
`define PPT_ADR_STAT      8'h04
`define PPT_CTRL_RST      1'b1

`endif

/* File: rtl/ppt_pkg.sv */
package ppt_pkg;

  // connection state, one-hot
  typedef enum logic [1:0] {
    PPT_DISC = 2'b01,
    PPT_CONN = 2'b10
  } ppt_conn_e;

  // data channel lines toward the device
  typedef struct packed {
    logic [11:0] data;
    logic        par;
    logic        conn;
    logic        func;
    logic        wr;
    logic        clr;
  } ppt_chan_in_s;

  // plotter mechanism condition lines
  typedef struct packed {
    logic ready;
    logic busy;
    logic stop;
    logic eoo;
    logic abn;
  } ppt_plt_in_s;

  // whole state of the port
  typedef struct packed {
    ppt_chan_in_s ch_s1;
    ppt_chan_in_s ch_s2;
    logic [2:0]   stb_prev;
    ppt_plt_in_s  plt_s1;
    ppt_plt_in_s  plt_s2;
    logic [2:0]   eq_s1;
    logic [2:0]   eq_s2;
    logic         mclr_s1;
    logic         mclr_s2;
    ppt_conn_e    conn;
    logic         par_err;
    logic         char_mode;
    logic [2:0]   sel;
    logic [2:0]   irq;
    logic         reply;
    logic         reject;
    logic         perr;
    logic [11:0]  plt_data;
    logic         plt_stb;
    logic [11:0]  status;
    logic         status_en;
    logic [7:0]   int_lines;
    logic         ctrl_en;
    logic         wb_ack;
    logic [31:0]  wb_dat;
  } ppt_state_s;

endpackage

/* File: rtl/ppt_host_port.sv */
// Functional notes
// - function and write transfers are ignored unless connected.
// - connect only when unit field matches switch and parity good; reply.
// - foreign unit number: no answer, status withheld, disconnect.
// - connect parity error: no connect, disconnect, no answer, lamp on.
// - parity errors stay latched until clear; connects refused meanwhile.
// - one function at a time; parity first, then reply or reject.
// - undefined function codes get a reply and do nothing.
// - function parity error: not executed, error signal, lamp, no answer.
// - after function parity error a new connect is needed.
// - interrupt rises when a selected group condition occurs; code raises it only while connected.
// - interrupt holds until reselect, release, clear or master clear.
// - interrupt goes out on the line indexed by the switch.
// - status word presented on 12 lines after a connect.
// - several conditions give a sum of separate bits.
// - senders drive parity high when the word has even ones.
// - even ones over data plus parity flags a parity error.
// - write parity error: lamp, reply plus error signal, data passed.
// - code 0000 clears and disconnects; 0005 clears only.
// - 0020..0025 select and release the three groups, always replied.
// - status bits 0,1,2 ready, busy, stop; bits 7..9 live conditions of the selected groups.
//
// Register access over Wishbone and the address map were chosen for this implementation.
`include "ppt_defines.svh"

module ppt_host_port
  import ppt_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire ppt_chan_in_s i_ch,
  input  wire logic         i_mclr,
  input  wire logic [2:0]   i_equip_num,
  input  wire ppt_plt_in_s  i_plt,
  output logic              o_ch_reply,
  output logic              o_ch_reject,
  output logic              o_ch_par_err,
  output logic [11:0]       o_ch_status,
  output logic              o_ch_status_en,
  output logic [7:0]        o_ch_int,
  output logic [11:0]       o_plt_data,
  output logic              o_plt_stb,
  output logic              o_plt_char_mode,
  output logic              o_par_lamp,
  output logic              o_conn_lamp,
  input  wire logic         i_wb_cyc,
  input  wire logic         i_wb_stb,
  input  wire logic         i_wb_we,
  input  wire logic [7:0]   i_wb_adr,
  input  wire logic [3:0]   i_wb_sel,
  input  wire logic [31:0]  i_wb_dat,
  output logic [31:0]       o_wb_dat,
  output logic              o_wb_ack
);

  ppt_state_s q;
  ppt_state_s d;

  logic        conn_ev;
  logic        func_ev;
  logic        wr_ev;
  logic        par_ok;
  logic        clr_all;
  logic        conn_on;
  logic [2:0]  cond;
  logic [11:0] fc;

  // edge detects read only the second sync stage
  assign conn_ev = q.ch_s2.conn & ~q.stb_prev[2];
  assign func_ev = q.ch_s2.func & ~q.stb_prev[1];
  assign wr_ev   = q.ch_s2.wr & ~q.stb_prev[0];
  assign par_ok  = ^{q.ch_s2.data, q.ch_s2.par};
  assign clr_all = q.ch_s2.clr | q.mclr_s2;
  assign conn_on = (q.conn == PPT_CONN);
  assign fc      = q.ch_s2.data;
  // group conditions: ready and not busy, end of op, abnormal end
  assign cond    = {q.plt_s2.abn, q.plt_s2.eoo,
                    q.plt_s2.ready & ~q.plt_s2.busy};

  // next-state logic for the whole port
  always_comb
  begin
    d = q;
    // pins pass two flops; data assumed settled before its strobe
    d.ch_s1    = i_ch;
    d.ch_s2    = q.ch_s1;
    d.stb_prev = {q.ch_s2.conn, q.ch_s2.func, q.ch_s2.wr};
    d.plt_s1   = i_plt;
    d.plt_s2   = q.plt_s1;
    d.eq_s1    = i_equip_num;
    d.eq_s2    = q.eq_s1;
    d.mclr_s1  = i_mclr;
    d.mclr_s2  = q.mclr_s1;
    d.reply    = 1'b0;
    d.reject   = 1'b0;
    d.perr     = 1'b0;
    d.plt_stb  = 1'b0;

    d.irq = q.irq | (q.sel & cond & {3{conn_on}});

    if (clr_all)
    begin
      d.conn      = PPT_DISC;
      d.par_err   = 1'b0;
      d.char_mode = 1'b0;
      d.sel       = 3'h0;
      d.irq       = 3'h0;
    end
    else if (q.ctrl_en && conn_ev && !q.par_err)
    begin
      // connects refused while an error is latched
      if (!par_ok)
      begin
        d.conn    = PPT_DISC;
        d.par_err = 1'b1;
      end
      else if (fc[11:`PPT_CONN_N_LSB] == q.eq_s2)
      begin
        d.conn  = PPT_CONN;
        d.reply = 1'b1;
      end
      else
      begin
        d.conn = PPT_DISC;
      end
    end
    else if (q.ctrl_en && func_ev && conn_on)
    begin
      if (!par_ok)
      begin
        // drop link so a reconnect is needed
        d.perr    = 1'b1;
        d.par_err = 1'b1;
        d.conn    = PPT_DISC;
      end
      else
      begin
        // every code replied, unknown ones do nothing
        d.reply = 1'b1;
        if (fc == `PPT_FC_REL_DISC || fc == `PPT_FC_CLEAR)
        begin
          d.sel       = 3'h0;
          d.irq       = 3'h0;
          d.char_mode = 1'b0;
          if (fc == `PPT_FC_REL_DISC)
          begin
            d.conn = PPT_DISC;
          end
        end
        else if (fc == `PPT_FC_DISASM)
        begin
          d.char_mode = 1'b0;
        end
        else if (fc == `PPT_FC_CHAR)
        begin
          d.char_mode = 1'b1;
        end
        else
        begin
          for (int g = 0; g < 3; g++)
          begin
            if (fc == `PPT_FC_SEL_BASE + 12'(2 * g))
            begin
              d.sel[g] = 1'b1;
              d.irq[g] = 1'b0;
            end
            else if (fc == `PPT_FC_REL_BASE + 12'(2 * g))
            begin
              d.sel[g] = 1'b0;
              d.irq[g] = 1'b0;
            end
          end
        end
      end
    end
    else if (q.ctrl_en && wr_ev && conn_on)
    begin
      if (!q.plt_s2.ready)
      begin
        // mechanism off line: write cannot be performed
        d.reject = 1'b1;
      end
      else
      begin
        // data still passed; error reported with the reply
        d.reply    = 1'b1;
        d.plt_data = q.ch_s2.data;
        d.plt_stb  = 1'b1;
        if (!par_ok)
        begin
          d.perr    = 1'b1;
          d.par_err = 1'b1;
        end
      end
    end

    d.status_en = (d.conn == PPT_CONN);
    d.status    = 12'h000;
    d.status[`PPT_ST_READY] = q.plt_s2.ready;
    d.status[`PPT_ST_BUSY]  = q.plt_s2.busy;
    d.status[`PPT_ST_STOP]  = q.plt_s2.stop;
    d.status[`PPT_ST_IRQ_LSB +: 3] = q.sel & cond;

    // one line chosen by the switch
    d.int_lines = (|q.irq) ? (8'h01 << q.eq_s2) : 8'h00;

    // wishbone slave: ack one cycle after request, dropped next cycle
    d.wb_ack = i_wb_cyc & i_wb_stb & ~q.wb_ack;
    d.wb_dat = 32'h0000_0000;
    if (i_wb_cyc && i_wb_stb && !q.wb_ack)
    begin
      if (i_wb_adr == `PPT_ADR_CTRL)
      begin
        if (i_wb_we && i_wb_sel[0])
        begin
          d.ctrl_en = i_wb_dat[0];
        end
        d.wb_dat[0] = q.ctrl_en;
      end
      else if (i_wb_adr == `PPT_ADR_STAT)
      begin
        // writes ignored; unmapped reads give zero
        d.wb_dat[15:0] = {2'b00, q.irq, q.sel, q.char_mode,
                          q.par_err, conn_on, q.eq_s2, q.conn};
      end
    end
  end

  // single state register; async reset loads constants only
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q         <= '0;
      q.conn    <= PPT_DISC;
      q.ctrl_en <= `PPT_CTRL_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // outputs straight from flops, except o_conn_lamp decoded from q.conn
  assign o_ch_reply      = q.reply;
  assign o_ch_reject     = q.reject;
  assign o_ch_par_err    = q.perr;
  assign o_ch_status     = q.status;
  assign o_ch_status_en  = q.status_en;
  assign o_ch_int        = q.int_lines;
  assign o_plt_data      = q.plt_data;
  assign o_plt_stb       = q.plt_stb;
  assign o_plt_char_mode = q.char_mode;
  assign o_par_lamp      = q.par_err;
  assign o_conn_lamp     = conn_on;
  assign o_wb_dat        = q.wb_dat;
  assign o_wb_ack        = q.wb_ack;

endmodule

/* File: test/ppt_host_port_sva.sv */
module ppt_chk
  import ppt_pkg::*;
(
  input wire logic         i_clk,
  input wire logic         i_rst_n,
  input wire ppt_chan_in_s i_ch,
  input wire logic         i_mclr,
  input wire logic [2:0]   i_equip_num,
  input wire logic         o_ch_reply,
  input wire logic         o_ch_reject,
  input wire logic         o_ch_par_err,
  input wire logic         o_ch_status_en,
  input wire logic [7:0]   o_ch_int,
  input wire logic         o_plt_stb,
  input wire logic         o_par_lamp,
  input wire logic         o_conn_lamp,
  input wire logic         i_wb_cyc,
  input wire logic         i_wb_stb,
  input wire logic         o_wb_ack
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ans_excl_a: assert property (!(o_ch_reply && o_ch_reject))
    else $error("reply and reject together");
  reply_pulse_a: assert property (o_ch_reply |=> !o_ch_reply)
    else $error("reply longer than one cycle");
  perr_norej_a: assert property (o_ch_par_err |-> !o_ch_reject)
    else $error("parity error with reject");
  conn_reply_a: assert property ($rose(o_conn_lamp) |-> o_ch_reply)
    else $error("connected without reply");
  stat_conn_a: assert property (o_ch_status_en == o_conn_lamp)
    else $error("status shown while disconnected");
  rej_conn_a: assert property (o_ch_reject |-> o_conn_lamp)
    else $error("answer while disconnected");
  int_line_a: assert property (
    o_ch_int != 8'h00 |-> o_ch_int == (8'h01 << i_equip_num))
    else $error("interrupt on wrong line");
  lamp_hold_a: assert property (
    o_par_lamp && !i_ch.clr && !i_mclr |=> o_par_lamp)
    else $error("parity lamp dropped without clear");
  stb_reply_a: assert property (o_plt_stb |-> o_ch_reply)
    else $error("data passed without reply");
  wb_ack_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus request not acknowledged");
endmodule

bind ppt_host_port ppt_chk u_chk (.*);

/* File: test/ppt_chan_model.sv */
module ppt_chan_model
  import ppt_pkg::*;
#(
  parameter int TMO = 8
)
(
  input  wire logic   i_clk,
  input  wire logic   i_reply,
  input  wire logic   i_reject,
  input  wire logic   i_perr,
  output ppt_chan_in_s o_ch
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_ch = '0;
  // long clear level so the two-flop sync surely sees it
  task automatic clear();
    @(posedge i_clk) o_ch.clr <= 1'b1;
    repeat (6) @(posedge i_clk);
    o_ch.clr <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
  // k: 0 connect, 1 function, 2 write; ans collects reply,reject,error
  task automatic xfer(input int k, input logic [11:0] d, input bit bad,
                      output logic [2:0] ans);
    ans = 3'b000;
    @(posedge i_clk);
    o_ch.data <= d;
    o_ch.par <= ~(^d) ^ bad;
    @(posedge i_clk);
    o_ch.conn <= (k == 0);
    o_ch.func <= (k == 1);
    o_ch.wr <= (k == 2);
    // no answer within the wait reads as silence
    for (int i = 0; i < TMO; i++)
    begin
      @(posedge i_clk);
      // reject handed back in ans; caller checks it
      // error line recorded as the low bit of ans
      ans = ans | {i_reply, i_reject, i_perr};
      if (i == 2)
        o_ch.conn <= 1'b0;
      if (i == 2)
        o_ch.func <= 1'b0;
      if (i == 2)
        o_ch.wr <= 1'b0;
    end
    // released lines no longer show the old word
    o_ch.data <= ~d;
    o_ch.par <= (^d) ^ bad;
  endtask
endmodule

/* File: test/ppt_host_port_tb.sv */
module ppt_host_port_tb;
  import ppt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] EQ = 3'h5;
  logic         i_clk = 1'b0;
  logic         i_rst_n = 1'b0;
  logic         i_mclr = 1'b0;
  logic [2:0]   i_equip_num = EQ;
  ppt_plt_in_s  i_plt = 5'b10000;
  ppt_chan_in_s i_ch;
  logic         o_ch_reply, o_ch_reject, o_ch_par_err, o_ch_status_en;
  logic         o_plt_stb, o_plt_char_mode, o_par_lamp, o_conn_lamp;
  logic [11:0]  o_ch_status, o_plt_data;
  logic [7:0]   o_ch_int, i_wb_adr = 8'h00;
  logic         i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0, o_wb_ack;
  logic [3:0]   i_wb_sel = 4'hf;
  logic [31:0]  i_wb_dat = 32'h0, o_wb_dat, r;
  logic [2:0]   a;
  int           error_cnt = 0;
  int           checks_done = 0;
  always #2 i_clk = ~i_clk;
  ppt_host_port u_dut (.*);
  ppt_chan_model #(.TMO(8)) u_ch (.i_clk(i_clk), .i_reply(o_ch_reply),
    .i_reject(o_ch_reject), .i_perr(o_ch_par_err), .o_ch(i_ch));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // single classic cycle, held until ack is seen at an edge
  task automatic wb(input logic we, input logic [7:0] ad,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'b11, we, ad, d};
    do @(posedge i_clk); while (o_wb_ack !== 1'b1 && ++n < 20);
    if (n >= 20)
    begin
      error_cnt++;
      close_out();
    end
    r = o_wb_dat;
    {i_wb_cyc, i_wb_stb} <= 2'b00;
  endtask
  task automatic cn(input bit bad);
    u_ch.xfer(0, {EQ, 9'h000}, bad, a);
  endtask
  // main sequence
  initial
  begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    wb(1'b0, 8'h00, 0); chk(r, 32'h1);
    wb(1'b0, 8'h04, 0); chk(r, {27'h0, EQ, 2'b01});
    wb(1'b0, 8'h40, 0); chk(r, 32'h0);
    u_ch.xfer(1, 12'o0002, 0, a); chk(a, 3'b000);
    u_ch.xfer(0, {~EQ, 9'h0}, 0, a); chk({a, o_ch_status_en}, 0);
    cn(0); chk({a, o_ch_status}, {3'b100, 12'h001});
    u_ch.xfer(1, 12'o0002, 0, a); chk({a, o_plt_char_mode}, 4'h9);
    u_ch.xfer(1, 12'o0003, 0, a); chk({a, o_plt_char_mode}, 4'h9);
    u_ch.xfer(1, 12'o0005, 0, a); chk({a, o_plt_char_mode}, 4'h8);
    u_ch.xfer(1, 12'o0020, 0, a); chk(a, 3'b100);
    chk({o_ch_int, o_ch_status}, {8'h20, 12'h081});
    i_plt.busy <= 1'b1;
    repeat (5) @(posedge i_clk);
    chk({o_ch_int, o_ch_status}, {8'h20, 12'h003});
    u_ch.xfer(1, 12'o0021, 0, a); chk({a, o_ch_int}, {3'b100, 8'h0});
    i_plt <= 5'b00000;
    u_ch.xfer(2, 12'h0a5, 0, a); chk(a, 3'b010);
    i_plt <= 5'b10000;
    u_ch.xfer(2, 12'h3c3, 1, a);
    chk({a, o_plt_data, o_par_lamp}, {3'b101, 12'h3c3, 1'b1});
    u_ch.clear(); chk({o_par_lamp, o_conn_lamp}, 0);
    cn(1); chk({a, o_par_lamp, o_conn_lamp}, 5'b00010);
    cn(0); chk(a, 3'b000);
    i_mclr <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_mclr <= 1'b0;
    repeat (4) @(posedge i_clk);
    cn(0); chk({a, o_par_lamp}, 4'h8);
    u_ch.xfer(1, 12'o0001, 1, a);
    chk({a, o_par_lamp, o_conn_lamp}, 5'b00110);
    u_ch.clear();
    u_ch.xfer(1, 12'o0002, 0, a); chk(a, 3'b000);
    cn(0);
    u_ch.xfer(1, 12'o0000, 0, a); chk({a, o_conn_lamp}, 4'h8);
    wb(1'b1, 8'h00, 0);
    cn(0); chk(a, 3'b000);
    wb(1'b1, 8'h00, 1);
    cn(0); chk(a, 3'b100);
    close_out();
  end
  // watchdog well beyond the few hundred cycles of the sequence
  initial
  begin
    repeat (5000) @(posedge i_clk);
    error_cnt++;
    close_out();
  end
endmodule
